//--- shared/aof_defines.svh
/*
 * Register offsets, field positions, reset values, pattern words and
 * timing figures of the output formatter and power-mode block.
 * Assumes inclusion by bare name from files that use these macros.
 */
`ifndef AOF_DEFINES_SVH
`define AOF_DEFINES_SVH

`define AOF_ADDR_W 8
`define AOF_ADDR_PWR 8'h00
`define AOF_ADDR_OUT 8'h04
`define AOF_ADDR_FMT 8'h08
`define AOF_ADDR_STAT 8'h0c

`define AOF_PWR_RESET 2'h0
`define AOF_OUT_RESET 3'h0
`define AOF_FMT_RESET 6'h00

`define AOF_OUT_DIS_BIT 0
`define AOF_OUT_LVDS_BIT 1
`define AOF_OUT_DCS_BIT 2

`define AOF_FMT_TWOS_BIT 0
`define AOF_FMT_RAND_BIT 1
`define AOF_FMT_ABP_BIT 2
`define AOF_FMT_PAT_EN_BIT 3
`define AOF_FMT_PAT_LO 4
`define AOF_FMT_PAT_HI 5

`define AOF_MSB_MASK 16'h8000
`define AOF_ABP_MASK 16'haaaa
`define AOF_FS_POS 16'hffff
`define AOF_FS_NEG 16'h0000
`define AOF_PAT_ONES 17'h1ffff
`define AOF_PAT_ZEROS 17'h00000
`define AOF_PAT_CHECK_A 17'h15555
`define AOF_PAT_CHECK_B 17'h0aaaa

`define AOF_PCLK_MHZ 40
`define AOF_SLEEP_WAKE_MS 2
`define AOF_NAP_WAKE_SAMPLES 7'h64

`endif

//--- shared/aof_pkg.sv
/*
 * Types of the output formatter and power-mode block.
 * Assumes every user names items as aof_pkg::name.
 */
package aof_pkg;

    // Order matters: position equals the two-bit power-down selection
    typedef enum logic [1:0] {
        aof_pd_normal,
        aof_pd_nap_ch2,
        aof_pd_nap_both,
        aof_pd_sleep
    } aof_pd_t;

    typedef enum logic [1:0] {
        aof_pat_ones,
        aof_pat_zeros,
        aof_pat_alt,
        aof_pat_checker
    } aof_pat_t;

    typedef enum logic [1:0] {
        aof_wk_run,
        aof_wk_asleep,
        aof_wk_waking
    } aof_wake_t;

endpackage

//--- rtl/aof_sync.sv
/*
 * Two-flop synchroniser for a vector of independent slow levels.
 * Assumes each bit is stable for several clock periods around use.
 */
`timescale 1ns/10ps

module aof_sync #(
    parameter int W = 1
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [W-1:0] d_in,
    output logic [W-1:0] q_out
);

    logic [W-1:0] meta;
    logic [W-1:0] next_meta;
    logic [W-1:0] next_q;

    always_comb begin
        next_meta = d_in;
        next_q = meta;
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            meta <= '0;
            q_out <= '0;
        end else begin
            meta <= next_meta;
            q_out <= next_q;
        end
    end

endmodule

//--- rtl/aof_formatter.sv
/*
 * Combinational sample formatter for one channel: clamp, coding,
 * randomizer, alternate polarity and test-pattern override.
 * Assumes the caller registers the result on each sample.
 */
`timescale 1ns/10ps
`include "aof_defines.svh"

module aof_formatter (
    input wire logic [15:0] raw_sample,
    input wire logic over_range,
    input wire logic under_range,
    input wire logic twos_en,
    input wire logic rand_en,
    input wire logic abp_en,
    input wire logic pat_en,
    input wire aof_pkg::aof_pat_t pat_kind,
    input wire logic pat_phase,
    output logic [15:0] fmt_bits,
    output logic fmt_overflow
);

    logic [15:0] word;
    logic ovf;
    logic [16:0] pat_word;

    always_comb begin
        word = raw_sample;
        ovf = over_range | under_range; // RULE23
        if (over_range) begin
            word = `AOF_FS_POS; // RULE24
        end else if (under_range) begin
            word = `AOF_FS_NEG; // RULE24
        end
        // Stage order is fixed: coding, then randomizer, then polarity
        if (twos_en) begin
            word = word ^ `AOF_MSB_MASK; // RULE1 RULE25
        end
        if (rand_en) begin
            word = word ^ {{15{word[0]}}, 1'b0}; // RULE2 RULE3
        end
        if (abp_en) begin
            word = word ^ `AOF_ABP_MASK; // RULE5 RULE6
        end
        case (pat_kind)
            aof_pkg::aof_pat_ones: pat_word = `AOF_PAT_ONES; // RULE9
            aof_pkg::aof_pat_zeros: pat_word = `AOF_PAT_ZEROS; // RULE9
            aof_pkg::aof_pat_alt: begin
                pat_word = pat_phase ? `AOF_PAT_ZEROS : `AOF_PAT_ONES; // RULE10
            end
            default: begin
                pat_word = pat_phase ? `AOF_PAT_CHECK_B
                                     : `AOF_PAT_CHECK_A; // RULE11
            end
        endcase
        if (pat_en) begin
            {ovf, word} = pat_word; // RULE12
        end
        fmt_bits = word;
        fmt_overflow = ovf;
    end

endmodule

//--- rtl/aof_output_top.sv
/*
 * Output formatter and power-mode control of a dual-channel 16-bit
 * converter, with an APB register slave. Holds the formatted output
 * registers, the forwarded clock, output enable and power state.
 * Assumes the encode clock and converter samples arrive asynchronously
 * and change no faster than every few pclk periods; the pad ring turns
 * the active-low output enable into the high-impedance state.
 */
// Chosen here: the register offsets and register access over APB.
`timescale 1ns/10ps
`include "aof_defines.svh"

// Overview of operation
// (RULE1) Offset binary by default, two's complement optional
// (RULE2) Randomizer XORs LSB into other bits
// (RULE3) Randomizer spares LSB, overflow, forwarded clock
// (RULE4) Receiver XORs LSB back to derandomize
// (RULE5) Alternate polarity inverts odd data bits
// (RULE6) Even bits, overflow, clock pass unchanged
// (RULE7) Receiver re-inverts odd bits
// (RULE8) Randomizer and polarity enabled independently
// (RULE9) Test pattern forces all ones or zeros
// (RULE10) Alternating pattern flips every sample
// (RULE11) Checkerboard pattern swaps each sample
// (RULE12) Test pattern overrides every other format
// (RULE13) Output disable floats all digital outputs
// (RULE14) Controller naps channels while outputs disabled
// (RULE15) Sleep powers everything down, 2 ms wake
// (RULE16) Nap wake needs 100 encode cycles
// (RULE17) Controller waits 50 us for DC settling
// (RULE18) Never nap channel 1 alone
// (RULE19) Interface select high makes pins static modes
// (RULE20) Stabilizer pin switches duty stabilizer
// (RULE21) Output mode pin picks CMOS or LVDS
// (RULE22) Power-down selection decodes four states
// (RULE23) Overflow marks over or under range
// (RULE24) Clamp data to full scale on overflow
// (RULE25) Coding, randomizer, polarity in fixed order
module aof_output_top #(
    parameter int SLEEP_WAKE_CYCLES =
        `AOF_SLEEP_WAKE_MS * 1000 * `AOF_PCLK_MHZ
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [`AOF_ADDR_W-1:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic enc_clk,
    input wire logic [15:0] raw_ch1_sample,
    input wire logic raw_ch1_over,
    input wire logic raw_ch1_under,
    input wire logic [15:0] raw_ch2_sample,
    input wire logic raw_ch2_over,
    input wire logic raw_ch2_under,
    input wire logic interface_select_pin,
    input wire logic stabilizer_mode_pin,
    input wire logic output_mode_pin,
    input wire logic power_mode_pin_high,
    input wire logic power_mode_pin_low,
    output logic [15:0] sample_bits_ch1,
    output logic overflow_flag_ch1,
    output logic [15:0] sample_bits_ch2,
    output logic overflow_flag_ch2,
    output logic forwarded_output_clock,
    output logic outputs_oe_n,
    output logic stabilizer_on,
    output logic lvds_mode,
    output logic ch1_nap,
    output logic ch2_nap,
    output logic sleep_mode,
    output logic ch1_data_valid,
    output logic ch2_data_valid
);

    localparam int SYNC_W = 42;

    logic [SYNC_W-1:0] sync_q;
    logic par_mode;
    logic s_stab;
    logic s_outmode;
    logic s_pm_high;
    logic s_pm_low;
    logic s_enc;
    logic [15:0] raw [2];
    logic over [2];
    logic under [2];

    aof_sync #(.W(SYNC_W)) u_sync (
        .clk(pclk),
        .rst_n(presetn),
        .d_in({interface_select_pin, stabilizer_mode_pin, output_mode_pin,
               power_mode_pin_high, power_mode_pin_low, enc_clk,
               raw_ch2_over, raw_ch2_under, raw_ch2_sample,
               raw_ch1_over, raw_ch1_under, raw_ch1_sample}),
        .q_out(sync_q)
    );

    assign {par_mode, s_stab, s_outmode, s_pm_high, s_pm_low, s_enc,
            over[1], under[1], raw[1], over[0], under[0], raw[0]} = sync_q;

    // Register file
    logic [1:0] pwr_reg;
    logic [2:0] out_reg;
    logic [5:0] fmt_reg;
    logic [1:0] next_pwr_reg;
    logic [2:0] next_out_reg;
    logic [5:0] next_fmt_reg;
    logic [31:0] next_prdata;
    logic [7:0] status;
    logic wr_go;

    function automatic logic addr_known(input logic [`AOF_ADDR_W-1:0] a);
        addr_known = (a == `AOF_ADDR_PWR) || (a == `AOF_ADDR_OUT) ||
                     (a == `AOF_ADDR_FMT) || (a == `AOF_ADDR_STAT);
    endfunction

    // Zero-wait slave: read data is captured in the setup cycle
    assign pready = 1'b1;
    assign pslverr = psel & penable & ~addr_known(paddr);
    assign wr_go = psel & penable & pwrite;

    always_comb begin
        next_pwr_reg = pwr_reg;
        next_out_reg = out_reg;
        next_fmt_reg = fmt_reg;
        next_prdata = prdata;
        if (wr_go) begin
            if (paddr == `AOF_ADDR_PWR) begin
                next_pwr_reg = pwdata[1:0];
            end else if (paddr == `AOF_ADDR_OUT) begin
                next_out_reg = pwdata[2:0];
            end else if (paddr == `AOF_ADDR_FMT) begin
                next_fmt_reg = pwdata[5:0]; // RULE8
            end
        end
        if (psel && !penable && !pwrite) begin
            if (paddr == `AOF_ADDR_PWR) begin
                next_prdata = {30'h0, pwr_reg};
            end else if (paddr == `AOF_ADDR_OUT) begin
                next_prdata = {29'h0, out_reg};
            end else if (paddr == `AOF_ADDR_FMT) begin
                next_prdata = {26'h0, fmt_reg};
            end else if (paddr == `AOF_ADDR_STAT) begin
                next_prdata = {24'h0, status};
            end else begin
                next_prdata = 32'h0;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pwr_reg <= `AOF_PWR_RESET;
            out_reg <= `AOF_OUT_RESET;
            fmt_reg <= `AOF_FMT_RESET;
            prdata <= 32'h0;
        end else begin
            pwr_reg <= next_pwr_reg;
            out_reg <= next_out_reg;
            fmt_reg <= next_fmt_reg;
            prdata <= next_prdata;
        end
    end

    // Effective configuration; pins take over when strapped parallel
    aof_pkg::aof_pd_t pd_sel;
    logic twos_en;
    logic rand_en;
    logic abp_en;
    logic pat_en;
    aof_pkg::aof_pat_t pat_kind;
    logic out_dis;

    always_comb begin
        if (par_mode) begin
            pd_sel = aof_pkg::aof_pd_t'({s_pm_high, s_pm_low}); // RULE19
        end else begin
            pd_sel = aof_pkg::aof_pd_t'(pwr_reg);
        end
        // Formats cannot be reached from pins, so they fall back to default
        twos_en = ~par_mode & fmt_reg[`AOF_FMT_TWOS_BIT]; // RULE1
        rand_en = ~par_mode & fmt_reg[`AOF_FMT_RAND_BIT]; // RULE8
        abp_en = ~par_mode & fmt_reg[`AOF_FMT_ABP_BIT]; // RULE8
        pat_en = ~par_mode & fmt_reg[`AOF_FMT_PAT_EN_BIT];
        pat_kind = aof_pkg::aof_pat_t'(
            fmt_reg[`AOF_FMT_PAT_HI:`AOF_FMT_PAT_LO]);
        out_dis = ~par_mode & out_reg[`AOF_OUT_DIS_BIT];
    end

    // Channel 1 naps only together with channel 2
    function automatic logic [2:0] pd_decode(input aof_pkg::aof_pd_t p);
        case (p)
            aof_pkg::aof_pd_nap_ch2: pd_decode = 3'b010; // RULE22
            aof_pkg::aof_pd_nap_both: pd_decode = 3'b011; // RULE18
            aof_pkg::aof_pd_sleep: pd_decode = 3'b100; // RULE22
            default: pd_decode = 3'b000;
        endcase
    endfunction

    logic [2:0] pd_dec;
    logic dev_sleep;
    logic nap [2];
    assign pd_dec = pd_decode(pd_sel);
    assign dev_sleep = pd_dec[2];
    assign nap[0] = pd_dec[0];
    assign nap[1] = pd_dec[1];

    // Sleep state machine and wake timer
    aof_pkg::aof_wake_t wake_state;
    aof_pkg::aof_wake_t next_wake_state;
    logic [16:0] sleep_cnt;
    logic [16:0] next_sleep_cnt;
    logic dev_up;

    always_comb begin
        next_wake_state = wake_state;
        next_sleep_cnt = sleep_cnt;
        case (wake_state)
            aof_pkg::aof_wk_run: begin
                if (dev_sleep) begin
                    next_wake_state = aof_pkg::aof_wk_asleep; // RULE15
                end
            end
            aof_pkg::aof_wk_asleep: begin
                next_sleep_cnt = 17'h0;
                if (!dev_sleep) begin
                    next_wake_state = aof_pkg::aof_wk_waking;
                end
            end
            default: begin
                if (dev_sleep) begin
                    next_wake_state = aof_pkg::aof_wk_asleep;
                end else if (sleep_cnt == 17'(SLEEP_WAKE_CYCLES - 1)) begin
                    next_wake_state = aof_pkg::aof_wk_run; // RULE15
                end else begin
                    next_sleep_cnt = sleep_cnt + 17'h1;
                end
            end
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wake_state <= aof_pkg::aof_wk_run;
            sleep_cnt <= 17'h0;
        end else begin
            wake_state <= next_wake_state;
            sleep_cnt <= next_sleep_cnt;
        end
    end

    assign dev_up = (wake_state == aof_pkg::aof_wk_run);

    // Sample path, running off the falling edge of the encode clock
    logic enc_prev;
    logic sample_edge;
    logic pat_phase;
    logic [6:0] nap_cnt [2];
    logic [15:0] data_q [2];
    logic of_q [2];
    logic [15:0] fmt_bits [2];
    logic fmt_of [2];
    logic upd [2];
    logic next_pat_phase;
    logic [6:0] next_nap_cnt [2];
    logic [15:0] next_data_q [2];
    logic next_of_q [2];

    assign sample_edge = enc_prev & ~s_enc;

    for (genvar c = 0; c < 2; c++) begin : g_ch
        aof_formatter u_fmt (
            .raw_sample(raw[c]),
            .over_range(over[c]),
            .under_range(under[c]),
            .twos_en(twos_en),
            .rand_en(rand_en),
            .abp_en(abp_en),
            .pat_en(pat_en),
            .pat_kind(pat_kind),
            .pat_phase(pat_phase),
            .fmt_bits(fmt_bits[c]),
            .fmt_overflow(fmt_of[c])
        );
        assign upd[c] = sample_edge & dev_up & ~nap[c];
    end

    always_comb begin
        next_pat_phase = pat_phase;
        if (!pat_en) begin
            next_pat_phase = 1'b0;
        end else if (sample_edge) begin
            next_pat_phase = ~pat_phase; // RULE10 RULE11
        end
        for (int c = 0; c < 2; c++) begin
            next_data_q[c] = data_q[c];
            next_of_q[c] = of_q[c];
            next_nap_cnt[c] = nap_cnt[c];
            if (upd[c]) begin
                next_data_q[c] = fmt_bits[c];
                next_of_q[c] = fmt_of[c]; // RULE23
            end
            // A napping core restarts its wake count from zero
            if (nap[c] || !dev_up) begin
                next_nap_cnt[c] = 7'h0; // RULE16
            end else if (sample_edge &&
                         nap_cnt[c] != `AOF_NAP_WAKE_SAMPLES) begin
                next_nap_cnt[c] = nap_cnt[c] + 7'h1; // RULE16
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            enc_prev <= 1'b0;
            pat_phase <= 1'b0;
            for (int c = 0; c < 2; c++) begin
                data_q[c] <= 16'h0;
                of_q[c] <= 1'b0;
                nap_cnt[c] <= 7'h0;
            end
        end else begin
            enc_prev <= s_enc;
            pat_phase <= next_pat_phase;
            for (int c = 0; c < 2; c++) begin
                data_q[c] <= next_data_q[c];
                of_q[c] <= next_of_q[c];
                nap_cnt[c] <= next_nap_cnt[c];
            end
        end
    end

    // Pin-facing outputs, all registered
    logic next_oe_n;
    logic next_stab;
    logic next_lvds;

    always_comb begin
        next_oe_n = out_dis; // RULE13
        next_stab = par_mode ? s_stab : out_reg[`AOF_OUT_DCS_BIT]; // RULE20
        next_lvds = par_mode ? s_outmode : out_reg[`AOF_OUT_LVDS_BIT]; // RULE21
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            outputs_oe_n <= 1'b0;
            stabilizer_on <= 1'b0;
            lvds_mode <= 1'b0;
            ch1_nap <= 1'b0;
            ch2_nap <= 1'b0;
            sleep_mode <= 1'b0;
            ch1_data_valid <= 1'b0;
            ch2_data_valid <= 1'b0;
        end else begin
            outputs_oe_n <= next_oe_n;
            stabilizer_on <= next_stab;
            lvds_mode <= next_lvds;
            ch1_nap <= nap[0];
            ch2_nap <= nap[1];
            sleep_mode <= dev_sleep;
            ch1_data_valid <= ~nap[0] & dev_up &
                (next_nap_cnt[0] == `AOF_NAP_WAKE_SAMPLES);
            ch2_data_valid <= ~nap[1] & dev_up &
                (next_nap_cnt[1] == `AOF_NAP_WAKE_SAMPLES);
        end
    end

    // The forwarded clock falls in the cycle the data changes
    assign forwarded_output_clock = enc_prev; // RULE3 RULE6
    assign sample_bits_ch1 = data_q[0];
    assign overflow_flag_ch1 = of_q[0];
    assign sample_bits_ch2 = data_q[1];
    assign overflow_flag_ch2 = of_q[1];
    assign status = {stabilizer_on, lvds_mode, dev_up, ch2_data_valid,
                     ch1_data_valid, par_mode, pd_sel};

    // Helper: alternating pattern held over two consecutive updates
    logic alt_prev;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            alt_prev <= 1'b0;
        end else if (sample_edge) begin
            alt_prev <= upd[0] & pat_en & (pat_kind == aof_pkg::aof_pat_alt);
        end
    end

    sequence s_plain_upd;
        upd[0] && !pat_en && !over[0] && !under[0];
    endsequence
    sequence s_alt_upd;
        upd[0] && pat_en && pat_kind == aof_pkg::aof_pat_alt && alt_prev;
    endsequence
    sequence s_nap_end;
        $fell(ch2_nap) && !sleep_mode;
    endsequence
    sequence s_sleep_end;
        $fell(sleep_mode);
    endsequence

    property p_twos;
        @(posedge pclk) disable iff (!presetn)
        s_plain_upd and (twos_en && !rand_en && !abp_en) |=>
            sample_bits_ch1 == ($past(raw[0]) ^ `AOF_MSB_MASK);
    endproperty
    a_twos: assert property (p_twos) // RULE1
        else $error("two's complement coding wrong");

    property p_rand;
        @(posedge pclk) disable iff (!presetn)
        s_plain_upd and (!twos_en && rand_en && !abp_en) |=>
            sample_bits_ch1[15:1] ==
                ($past(raw[0][15:1]) ^ {15{$past(raw[0][0])}});
    endproperty
    a_rand: assert property (p_rand) // RULE2
        else $error("randomizer output wrong");

    property p_lsb_keep;
        @(posedge pclk) disable iff (!presetn)
        s_plain_upd |=> sample_bits_ch1[0] == $past(raw[0][0]) &&
            overflow_flag_ch1 == 1'b0;
    endproperty
    a_lsb_keep: assert property (p_lsb_keep) // RULE3
        else $error("lsb or overflow changed by formatting");

    property p_abp;
        @(posedge pclk) disable iff (!presetn)
        s_plain_upd and (!twos_en && !rand_en && abp_en) |=>
            sample_bits_ch1 == ($past(raw[0]) ^ `AOF_ABP_MASK);
    endproperty
    a_abp: assert property (p_abp) // RULE5
        else $error("alternate polarity output wrong");

    property p_ones;
        @(posedge pclk) disable iff (!presetn)
        upd[0] && pat_en && pat_kind == aof_pkg::aof_pat_ones |=>
            {overflow_flag_ch1, sample_bits_ch1} == `AOF_PAT_ONES;
    endproperty
    a_ones: assert property (p_ones) // RULE9
        else $error("all-ones pattern wrong");

    property p_alt;
        @(posedge pclk) disable iff (!presetn)
        s_alt_upd |=> {overflow_flag_ch1, sample_bits_ch1} ==
            ~$past({overflow_flag_ch1, sample_bits_ch1});
    endproperty
    a_alt: assert property (p_alt) // RULE10
        else $error("alternating pattern did not flip");

    property p_clamp;
        @(posedge pclk) disable iff (!presetn)
        upd[0] && !pat_en && over[0] && !twos_en && !rand_en && !abp_en
            |=> sample_bits_ch1 == `AOF_FS_POS && overflow_flag_ch1;
    endproperty
    a_clamp: assert property (p_clamp) // RULE24
        else $error("over-range clamp wrong");

    property p_disable;
        @(posedge pclk) disable iff (!presetn)
        out_dis |=> outputs_oe_n;
    endproperty
    a_disable: assert property (p_disable) // RULE13
        else $error("outputs not floated when disabled");

    property p_no_ch1_nap;
        @(posedge pclk) disable iff (!presetn)
        ch1_nap |-> ch2_nap;
    endproperty
    a_no_ch1_nap: assert property (p_no_ch1_nap) // RULE18
        else $error("channel 1 napping alone");

    property p_nap_wake;
        @(posedge pclk) disable iff (!presetn)
        s_nap_end |-> !ch2_data_valid [*8];
    endproperty
    a_nap_wake: assert property (p_nap_wake) // RULE16
        else $error("data valid too soon after nap");

    property p_sleep_wake;
        @(posedge pclk) disable iff (!presetn)
        s_sleep_end |-> !dev_up [*8];
    endproperty
    a_sleep_wake: assert property (p_sleep_wake) // RULE15
        else $error("device up too soon after sleep");

endmodule

//--- dv/aof_rx_model.sv
/* Receiver model: latches channel 1 on the forwarded clock rise and
   undoes polarity and randomizer. Assumes the bench sets the modes. */
`timescale 1ns/10ps
module aof_rx_model (
    input wire logic clk_fwd,
    input wire logic [15:0] bits,
    input wire logic of_in,
    input wire logic rand_on,
    input wire logic abp_on,
    output logic [16:0] rx_word,
    output logic [15:0] rx_dec
);
    logic [15:0] t;
    always @(posedge clk_fwd) begin
        rx_word <= {of_in, bits};
        t = abp_on ? bits ^ 16'haaaa : bits;
        rx_dec <= (rand_on && t[0]) ? t ^ 16'hfffe : t;
    end
endmodule

//--- dv/test_adc_output_formatter_power_modes.sv
/* Bench: APB master, encode clock, samples and pins, receiver model.
   Assumes the zero-wait slave and short sleep wake of the note. */
`timescale 1ns/10ps
module test_adc_output_formatter_power_modes;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [15:0] raw_ch1_sample, raw_ch2_sample, sample_bits_ch1;
    logic [15:0] sample_bits_ch2, rx_dec;
    logic [16:0] rx_word;
    logic enc_clk, raw_ch1_over, raw_ch1_under, raw_ch2_over;
    logic raw_ch2_under, interface_select_pin, stabilizer_mode_pin;
    logic output_mode_pin, power_mode_pin_high, power_mode_pin_low;
    logic overflow_flag_ch1, overflow_flag_ch2, forwarded_output_clock;
    logic outputs_oe_n, stabilizer_on, lvds_mode, ch1_nap, ch2_nap;
    logic sleep_mode, ch1_data_valid, ch2_data_valid, rx_rand, rx_abp;
    int failures, checks;
    aof_output_top #(.SLEEP_WAKE_CYCLES(20)) dut_u (.*);
    aof_rx_model rx_u (.clk_fwd(forwarded_output_clock),
        .bits(sample_bits_ch1), .of_in(overflow_flag_ch1),
        .rand_on(rx_rand), .abp_on(rx_abp), .rx_word, .rx_dec);
    task automatic cmp(string n, logic [31:0] e, logic [31:0] s);
        checks++;
        if (s !== e) begin
            failures++;
            $display("Error %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic apb(logic w, logic [7:0] a, logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    // Data is looked at mid-cycle, away from the edge that loads it
    task automatic smp(int n);
        repeat (n) @(posedge forwarded_output_clock);
        @(negedge pclk);
    endtask
    task automatic t_format();
        raw_ch1_sample <= 16'h1235;
        raw_ch2_sample <= 16'h1235;
        smp(3);
        cmp("offset", 32'h1235, sample_bits_ch1);
        cmp("ch2", 32'h1235, {overflow_flag_ch2, sample_bits_ch2});
        apb(1'b1, 8'h08, 32'h2);
        rx_rand <= 1'b1;
        smp(3);
        cmp("rand", 32'hedcb, sample_bits_ch1);
        cmp("derand", 32'h1235, rx_dec);
        apb(1'b1, 8'h08, 32'h7);
        rx_abp <= 1'b1;
        smp(3);
        cmp("both", 32'hc761, sample_bits_ch1);
        cmp("rx", 32'h0c761, rx_word);
        cmp("decoded", 32'h9235, rx_dec);
        apb(1'b1, 8'h08, 32'h4);
        smp(3);
        cmp("abp", 32'hb89f, sample_bits_ch1);
        $display("format test done");
    endtask
    task automatic t_clamp();
        apb(1'b1, 8'h08, 32'h1);
        smp(3);
        cmp("twos", 32'h9235, sample_bits_ch1);
        @(posedge pclk);
        raw_ch1_under <= 1'b1;
        smp(3);
        cmp("lo", 32'h18000, {overflow_flag_ch1, sample_bits_ch1});
        apb(1'b1, 8'h08, 32'h0);
        raw_ch1_under <= 1'b0;
        raw_ch1_over <= 1'b1;
        smp(3);
        cmp("hi", 32'h1ffff, {overflow_flag_ch1, sample_bits_ch1});
        $display("clamp test done");
    endtask
    task automatic t_pat(logic [5:0] f, logic [16:0] a, logic [16:0] b);
        logic [16:0] v;
        apb(1'b1, 8'h08, {26'h0, f});
        smp(3);
        v = {overflow_flag_ch1, sample_bits_ch1};
        cmp("pattern", (v === b) ? b : a, v);
        smp(1);
        cmp("next", (v === b) ? a : b, {overflow_flag_ch1, sample_bits_ch1});
        $display("pattern test done");
    endtask
    task automatic t_power();
        apb(1'b1, 8'h00, 32'h1);
        repeat (2) @(negedge pclk);
        cmp("nap2", 32'h2, {ch1_nap, ch2_nap, sleep_mode});
        apb(1'b1, 8'h00, 32'h2);
        apb(1'b1, 8'h04, 32'h1);
        repeat (2) @(negedge pclk);
        cmp("nap", 32'h6, {ch1_nap, ch2_nap, sleep_mode});
        cmp("oe", 32'h1, outputs_oe_n);
        apb(1'b1, 8'h04, 32'h0);
        apb(1'b1, 8'h00, 32'h0);
        repeat (700) @(negedge pclk);
        cmp("early", 32'h0, ch1_data_valid);
        repeat (150) @(negedge pclk);
        cmp("woke", 32'h3, {ch1_data_valid, ch2_data_valid});
        repeat (2000) @(negedge pclk);
        apb(1'b1, 8'h00, 32'h3);
        repeat (2) @(negedge pclk);
        cmp("sleep", 32'h1, sleep_mode);
        apb(1'b1, 8'h00, 32'h0);
        repeat (860) @(negedge pclk);
        cmp("up", 32'h1, ch1_data_valid);
        $display("power test done");
    endtask
    task automatic t_parallel();
        @(posedge pclk);
        raw_ch1_over <= 1'b0;
        interface_select_pin <= 1'b1;
        stabilizer_mode_pin <= 1'b1;
        output_mode_pin <= 1'b1;
        power_mode_pin_low <= 1'b1;
        repeat (8) @(negedge pclk);
        cmp("pins", 32'h1a, {stabilizer_on, lvds_mode, ch1_nap, ch2_nap,
            sleep_mode});
        $display("parallel test done");
    endtask
    task automatic complete_run();
        $display("checks %0d failures %0d", checks, failures);
        if (failures == 0 && checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    initial begin
        pclk = 1'b0;
        forever #12.5 pclk = ~pclk;
    end
    initial begin
        enc_clk = 1'b0;
        #7;
        forever #100 enc_clk = ~enc_clk;
    end
    initial begin
        #1_000_000;
        failures++;
        complete_run();
    end
    initial begin
        {presetn, psel, penable, pwrite, paddr, pwdata, rx_rand} = '0;
        {raw_ch1_sample, raw_ch2_sample, raw_ch1_over, raw_ch1_under} = '0;
        {raw_ch2_over, raw_ch2_under, interface_select_pin, rx_abp} = '0;
        {stabilizer_mode_pin, output_mode_pin, power_mode_pin_high} = '0;
        power_mode_pin_low = 1'b0;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, 8'h08, 32'h0);
        cmp("fmt", 32'h0, rd);
        apb(1'b0, 8'h10, 32'h0);
        cmp("unmapped", 32'h1, {31'h0, err});
        t_format();
        t_clamp();
        t_pat(6'h0f, 17'h1ffff, 17'h1ffff);
        t_pat(6'h1f, 17'h00000, 17'h00000);
        t_pat(6'h2f, 17'h1ffff, 17'h00000);
        t_pat(6'h3f, 17'h15555, 17'h0aaaa);
        t_power();
        t_parallel();
        complete_run();
    end
endmodule
